/* File: design/sclf_top.sv */
// Strap capture, output stagger control and line-fault status block
module sclf_top #(
  parameter int GPO_LIMIT_CYC = sclf_pkg::GPO_MAX_CYC
) (
  input  wire logic       CLK_SYS,
  input  wire logic       RST_N,
  input  wire logic       LOCAL_CTRL_CHANNEL_ENABLE,
  input  wire logic       GPIO0_DOUBLE_INPUT_STRAP_I,
  output logic            GPIO0_O,
  output logic            GPIO0_OE_N,
  input  wire logic       GPIO1_WORD_WIDTH_STRAP_I,
  output logic            GPIO1_O,
  output logic            GPIO1_OE_N,
  input  wire logic       BASE_BYPASS_SYNC_ENC_PIN,
  input  wire logic       SDA_ERROR_CORRECT_STRAP_I,
  output logic            SDA_O,
  output logic            SDA_OE_N,
  input  wire logic       SCL_OUTPUT_EDGE_STRAP_I,
  output logic            SCL_O,
  output logic            SCL_OE_N,
  input  wire logic       CC_SDA_PULL,
  input  wire logic       CC_SCL_PULL,
  output logic            CC_SDA_IN,
  output logic            CC_SCL_IN,
  output logic            BASE_BYPASS_SELECT,
  output logic            STRAP_VALID,
  output logic            LOCAL_CC_ACTIVE,
  output logic            DOUBLE_INPUT_MODE,
  output logic            WORD_WIDTH_32,
  output logic            SYNC_ENCODING_EN,
  output logic            ERROR_CORRECT_EN,
  output logic            OUTPUT_EDGE_FALLING,
  input  wire logic [1:0] NEGATIVE_WIRE_FAULT,
  input  wire logic [1:0] POSITIVE_WIRE_FAULT,
  output logic            LINE_FAULT_N,
  input  wire logic       REMOTE_INPUT_PIN,
  output logic            REMOTE_OUTPUT_PIN,
  output logic [2:0]      TAP_GROUP0,
  output logic [2:0]      TAP_GROUP1,
  output logic [2:0]      TAP_GROUP2,
  output logic [2:0]      TAP_GROUP3,
  output logic [2:0]      TAP_PIXEL_CLOCK_OUT,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic [7:0]      REG_RDATA
);
  import sclf_pkg::*;

  typedef struct packed {
    sclf_phase_t phase;
    logic [1:0]  settle;
    logic        lcc_en;
    logic        double_input_strap;
    logic        word_width_strap;
    logic        sync_encoding_strap;
    logic        edc;
    logic        es;
    logic        stag_dis;
    logic        gpio1_out;
    logic        gpio0_out;
    logic [1:0]  neg;
    logic [1:0]  pos;
    logic        fault_n;
    logic        remote_output_pin;
    logic [7:0]  rdata;
  } sclf_state_t;

  sclf_state_t st;
  sclf_state_t next_st;
  logic [9:0]  pin_sync;
  logic        s_lcc;
  logic        s_gpio0;
  logic        s_gpio1;
  logic        s_ms;
  logic        s_sda;
  logic        s_scl;
  logic [1:0]  s_neg;
  logic [1:0]  s_pos;
  logic        lcc_mode;

  initial begin
    if (GPO_LIMIT_CYC < 2 || GPO_LIMIT_CYC >= (1 << 20))
      $error("sclf_top: GPO_LIMIT_CYC out of range");
  end

  // Delay tap count for a delay in picoseconds
  function automatic logic [2:0] tap_of(input int ps);
    return 3'(ps / TAP_UNIT_PS);
  endfunction

  // Wire code that is not normal counts as a fault
  function automatic logic wire_bad(input logic [1:0] code);
    return code != WIRE_NORMAL;
  endfunction

  // Every strap pad and comparator level crosses in through two flops; REMOTE_INPUT_PIN is registered once
  sclf_sync #(.W(10)) u_pin_sync (
    .CLK_SYS (CLK_SYS),
    .RST_N   (RST_N),
    .D       ({LOCAL_CTRL_CHANNEL_ENABLE, GPIO0_DOUBLE_INPUT_STRAP_I,
               GPIO1_WORD_WIDTH_STRAP_I, BASE_BYPASS_SYNC_ENC_PIN,
               SDA_ERROR_CORRECT_STRAP_I, SCL_OUTPUT_EDGE_STRAP_I,
               NEGATIVE_WIRE_FAULT, POSITIVE_WIRE_FAULT}),
    .Q       (pin_sync)
  );

  assign {s_lcc, s_gpio0, s_gpio1, s_ms, s_sda, s_scl, s_neg, s_pos} =
    pin_sync;

  // Next-state logic
  always_comb begin
    next_st = st;
    case (st.phase)
      SCLF_SETTLE: begin
        // Wait until the synchroniser holds real pin levels
        if (st.settle == STRAP_SETTLE_CYC) begin
          next_st.phase  = SCLF_DONE;
          next_st.lcc_en = s_lcc;
          if (!s_lcc) begin
            next_st.double_input_strap  = s_gpio0;
            next_st.word_width_strap  = s_gpio1;
            next_st.sync_encoding_strap = s_ms;
            next_st.edc  = s_sda;
            next_st.es   = s_scl;
          end
        end else begin
          next_st.settle = st.settle + 2'h1;
        end
      end
      SCLF_DONE: begin
        // Straps stay frozen until the next power-up
        next_st.phase = SCLF_DONE;
      end
      default: next_st.phase = SCLF_SETTLE;
    endcase
    // Codes are reset junk until the synchroniser fills; hold normal
    if (st.phase == SCLF_DONE) begin
      next_st.neg     = s_neg;
      next_st.pos     = s_pos;
      next_st.fault_n = !(wire_bad(s_neg) || wire_bad(s_pos));
    end
    next_st.remote_output_pin     = REMOTE_INPUT_PIN;
    // Register writes
    if (REG_WR) begin
      if (REG_ADDR == ADDR_OUT_CTRL) begin
        next_st.stag_dis = REG_WDATA[STAG_DIS_BIT];
      end else if (REG_ADDR == ADDR_GPIO) begin
        next_st.gpio1_out = REG_WDATA[GPIO1_OUT_BIT];
        next_st.gpio0_out = REG_WDATA[GPIO0_OUT_BIT];
      end
    end
    // Register reads, unmapped addresses return zero
    if (REG_RD) begin
      if (REG_ADDR == ADDR_OUT_CTRL) begin
        next_st.rdata = 8'h00;
        next_st.rdata[STAG_DIS_BIT] = st.stag_dis;
      end else if (REG_ADDR == ADDR_GPIO) begin
        next_st.rdata = {4'h0, st.gpio1_out, s_gpio1,
                         st.gpio0_out, s_gpio0};
      end else if (REG_ADDR == ADDR_FAULT_STAT) begin
        next_st.rdata = {4'h0, st.neg, st.pos};
      end else begin
        next_st.rdata = 8'h00;
      end
    end
  end

  // State register
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      st           <= '0;
      st.phase     <= SCLF_SETTLE;
      st.stag_dis  <= STAG_DIS_RESET;
      st.gpio1_out <= GPIO_OUT_RESET;
      st.gpio0_out <= GPIO_OUT_RESET;
      st.neg       <= WIRE_NORMAL;
      st.pos       <= WIRE_NORMAL;
      st.fault_n   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Local channel only counts once the power-up level is known
  assign lcc_mode = (st.phase == SCLF_DONE) && st.lcc_en;

  // Open-drain pins only ever pull low, and never in strap mode
  assign GPIO0_O    = 1'b0;
  assign GPIO1_O    = 1'b0;
  assign SDA_O      = 1'b0;
  assign SCL_O      = 1'b0;
  assign GPIO0_OE_N = !(lcc_mode && !st.gpio0_out);
  assign GPIO1_OE_N = !(lcc_mode && !st.gpio1_out);
  assign SDA_OE_N   = !(lcc_mode && CC_SDA_PULL);
  assign SCL_OE_N   = !(lcc_mode && CC_SCL_PULL);
  assign CC_SDA_IN  = lcc_mode ? s_sda : 1'b1;
  assign CC_SCL_IN  = lcc_mode ? s_scl : 1'b1;
  assign BASE_BYPASS_SELECT = lcc_mode && s_ms;

  // Strap results; the five strap levels stay low while the local channel owns the pins
  assign STRAP_VALID         = st.phase == SCLF_DONE;
  assign LOCAL_CC_ACTIVE     = lcc_mode;
  assign DOUBLE_INPUT_MODE   = st.double_input_strap;
  assign WORD_WIDTH_32       = st.word_width_strap;
  assign SYNC_ENCODING_EN    = st.sync_encoding_strap;
  assign ERROR_CORRECT_EN    = st.edc;
  assign OUTPUT_EDGE_FALLING = st.es;

  assign LINE_FAULT_N      = st.fault_n;
  assign REMOTE_OUTPUT_PIN = st.remote_output_pin;
  assign REG_RDATA         = st.rdata;

  // Sub-ns skew cannot come from 4 ns logic, so taps feed pad delay cells
  assign TAP_GROUP0 = st.stag_dis ? 3'h0 : tap_of(DLY_GRP0_PS);
  assign TAP_GROUP1 = st.stag_dis ? 3'h0 : tap_of(DLY_GRP1_PS);
  assign TAP_GROUP2 = st.stag_dis ? 3'h0 : tap_of(DLY_GRP2_PS);
  assign TAP_GROUP3 = st.stag_dis ? 3'h0 : tap_of(DLY_GRP3_PS);
  assign TAP_PIXEL_CLOCK_OUT = st.stag_dis ? 3'h0 : tap_of(DLY_PCLK_PS);

  // Helper: cycles the remote output has disagreed with its input
  logic [19:0] gpo_lag;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      gpo_lag <= '0;
    end else begin
      gpo_lag <= (REMOTE_OUTPUT_PIN != REMOTE_INPUT_PIN) ? gpo_lag + 20'h1
                                                          : 20'h0;
    end
  end

  default clocking sclf_cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence seq_status_read;
    REG_RD && REG_ADDR == ADDR_FAULT_STAT;
  endsequence
  sequence seq_stag_write;
    REG_WR && REG_ADDR == ADDR_OUT_CTRL;
  endsequence
  AST_STAGGER_ON: assert property (
    !st.stag_dis |-> TAP_GROUP1 == 3'h2 && TAP_GROUP2 == 3'h4 &&
      TAP_GROUP3 == 3'h6 && TAP_PIXEL_CLOCK_OUT == 3'h3 && TAP_GROUP0 == 3'h0)
    else $error("stagger taps wrong while enabled");
  AST_STAGGER_WRITE: assert property (
    seq_stag_write |=> (st.stag_dis == $past(REG_WDATA[STAG_DIS_BIT])) &&
      ((TAP_GROUP3 == 3'h0) == st.stag_dis))
    else $error("stagger disable write not applied");
  AST_STRAP_MODE_QUIET: assert property (
    STRAP_VALID && !st.lcc_en |-> GPIO0_OE_N && GPIO1_OE_N && SDA_OE_N &&
      SCL_OE_N && !LOCAL_CC_ACTIVE && !BASE_BYPASS_SELECT)
    else $error("pins driven while in strap mode");
  AST_STRAP_CAPTURE: assert property (
    st.phase == SCLF_SETTLE && st.settle == STRAP_SETTLE_CYC && !s_lcc |=>
      DOUBLE_INPUT_MODE == $past(s_gpio0) && WORD_WIDTH_32 == $past(s_gpio1) &&
      SYNC_ENCODING_EN == $past(s_ms) && ERROR_CORRECT_EN == $past(s_sda))
    else $error("strap levels not captured");
  AST_EDGE_STRAP: assert property (
    st.phase == SCLF_SETTLE && st.settle == STRAP_SETTLE_CYC |=>
      OUTPUT_EDGE_FALLING == ($past(s_scl) && !$past(s_lcc)))
    else $error("edge strap not captured");
  AST_STRAP_HOLD: assert property (
    STRAP_VALID |=> STRAP_VALID && $stable({st.lcc_en, DOUBLE_INPUT_MODE,
      WORD_WIDTH_32, SYNC_ENCODING_EN, ERROR_CORRECT_EN, OUTPUT_EDGE_FALLING}))
    else $error("straps changed after capture");
  AST_FAULT_PIN: assert property (
    STRAP_VALID && (wire_bad(s_neg) || wire_bad(s_pos)) |=> !LINE_FAULT_N)
    else $error("fault output not asserted");
  AST_FAULT_RELEASE: assert property (
    LINE_FAULT_N == (st.neg == WIRE_NORMAL && st.pos == WIRE_NORMAL))
    else $error("fault output disagrees with status");
  AST_STATUS_READ: assert property (
    seq_status_read |=>
      REG_RDATA == {4'h0, $past(st.neg), $past(st.pos)})
    else $error("fault status read wrong");
  AST_WIRE_FIELDS: assert property (
    STRAP_VALID |=> st.neg == $past(NEGATIVE_WIRE_FAULT, 3) &&
      st.pos == $past(POSITIVE_WIRE_FAULT, 3))
    else $error("wire fields do not track comparators");
  AST_GPO_LATENCY: assert property (
    gpo_lag < 20'(GPO_LIMIT_CYC))
    else $error("remote output late");
endmodule

/* File: design/sclf_pkg.sv */
// Shared constants for the strap, stagger and line-fault block
package sclf_pkg;
  // Register addresses and fields
  localparam logic [7:0] ADDR_OUT_CTRL   = 8'h08;
  localparam logic [7:0] ADDR_GPIO       = 8'h0E;
  localparam logic [7:0] ADDR_FAULT_STAT = 8'h14;
  localparam int         STAG_DIS_BIT    = 3;
  localparam int         GPIO1_OUT_BIT   = 3;
  localparam int         GPIO0_OUT_BIT   = 1;
  localparam logic       STAG_DIS_RESET  = 1'b0;
  localparam logic       GPIO_OUT_RESET  = 1'b1;
  // Wire fault codes
  localparam logic [1:0] WIRE_TO_SUPPLY  = 2'h0;
  localparam logic [1:0] WIRE_TO_GROUND  = 2'h1;
  localparam logic [1:0] WIRE_NORMAL     = 2'h2;
  localparam logic [1:0] WIRE_OPEN       = 2'h3;
  // Output stagger delays in picoseconds, tap unit of the delay cells
  localparam int         TAP_UNIT_PS     = 250;
  localparam int         DLY_GRP0_PS     = 0;
  localparam int         DLY_GRP1_PS     = 500;
  localparam int         DLY_GRP2_PS     = 1000;
  localparam int         DLY_GRP3_PS     = 1500;
  localparam int         DLY_PCLK_PS     = 750;
  // Timing
  localparam int         CLK_PERIOD_NS   = 4;
  localparam int         GPO_MAX_NS      = 350000;
  localparam int         GPO_MAX_CYC     = GPO_MAX_NS / CLK_PERIOD_NS;
  localparam logic [1:0] STRAP_SETTLE_CYC = 2'h3;
  // Power-up capture phase
  typedef enum logic [0:0] {
    SCLF_SETTLE = 1'b0,
    SCLF_DONE   = 1'b1
  } sclf_phase_t;
endpackage

/* File: design/sclf_sync.sv */
// Two-flop synchroniser for a vector of asynchronous pin levels
module sclf_sync #(
  parameter int W = 1
) (
  input  wire logic         CLK_SYS,
  input  wire logic         RST_N,
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);
  import sclf_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sclf_sync_t;

  sclf_sync_t st;
  sclf_sync_t next_st;

  initial begin
    if (W < 1) $error("sclf_sync: W must be at least 1");
  end

  // First stage feeds only the second stage
  always_comb begin
    next_st.s1 = D;
    next_st.s2 = st.s1;
  end

  // Pins idle low thanks to the pad pulldowns
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign Q = st.s2;
endmodule

/* File: bench/sclf_far_end.sv */
// Far-end serializer model: cable wire states and spaced remote input
module sclf_far_end #(
  parameter int GAP_CYC = 8
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       want_level,
  input  wire logic [1:0] neg_code,
  input  wire logic [1:0] pos_code,
  output logic            remote_pin,
  output logic [1:0]      neg_wire,
  output logic [1:0]      pos_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap;
  // Cable wires carry whatever condition the bench puts on them
  assign neg_wire = neg_code;
  assign pos_wire = pos_code;
  // Hold each transition for GAP_CYC, as a real sender must
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remote_pin <= 1'b0;
      gap        <= 0;
    end else if (gap != 0) begin
      gap <= gap - 1;
    end else if (want_level != remote_pin) begin
      remote_pin <= want_level;
      gap        <= GAP_CYC;
    end
  end
endmodule

/* File: bench/strap_config_line_fault_status_test.sv */
// Testbench for the strap, stagger and line-fault block
module strap_config_line_fault_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sclf_pkg::*;
  logic clk, rst_n, local_ctrl_channel_enable, g0_drv, g1_drv, ms_pin, sda_drv, scl_drv;
  logic sda_pull, scl_pull, want, wr, rd, rin, rout;
  logic g0_o, g0_oe_n, g1_o, g1_oe_n, sda_o, sda_oe_n, scl_o, scl_oe_n;
  logic sda_in, scl_in, bypass, valid, cc_on, double_input_strap, w32, senc, ecc, fall;
  logic lf_n;
  logic [1:0] neg_code, pos_code, neg_w, pos_w;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] tap [5];
  int errors, cmp_count, cycles;
  int lf_low;
  // Open-drain wires: carry the bench drive level unless the DUT pulls them low
  wire g0_w  = g0_oe_n ? g0_drv : g0_o;
  wire g1_w  = g1_oe_n ? g1_drv : g1_o;
  wire sda_w = sda_oe_n ? sda_drv : sda_o;
  wire scl_w = scl_oe_n ? scl_drv : scl_o;

  sclf_top #(.GPO_LIMIT_CYC(8)) DUT (
    .CLK_SYS(clk), .RST_N(rst_n), .LOCAL_CTRL_CHANNEL_ENABLE(local_ctrl_channel_enable),
    .GPIO0_DOUBLE_INPUT_STRAP_I(g0_w), .GPIO0_O(g0_o),
    .GPIO0_OE_N(g0_oe_n), .GPIO1_WORD_WIDTH_STRAP_I(g1_w),
    .GPIO1_O(g1_o), .GPIO1_OE_N(g1_oe_n),
    .BASE_BYPASS_SYNC_ENC_PIN(ms_pin),
    .SDA_ERROR_CORRECT_STRAP_I(sda_w), .SDA_O(sda_o),
    .SDA_OE_N(sda_oe_n), .SCL_OUTPUT_EDGE_STRAP_I(scl_w),
    .SCL_O(scl_o), .SCL_OE_N(scl_oe_n), .CC_SDA_PULL(sda_pull),
    .CC_SCL_PULL(scl_pull), .CC_SDA_IN(sda_in), .CC_SCL_IN(scl_in),
    .BASE_BYPASS_SELECT(bypass), .STRAP_VALID(valid),
    .LOCAL_CC_ACTIVE(cc_on), .DOUBLE_INPUT_MODE(double_input_strap),
    .WORD_WIDTH_32(w32), .SYNC_ENCODING_EN(senc),
    .ERROR_CORRECT_EN(ecc), .OUTPUT_EDGE_FALLING(fall),
    .NEGATIVE_WIRE_FAULT(neg_w), .POSITIVE_WIRE_FAULT(pos_w),
    .LINE_FAULT_N(lf_n), .REMOTE_INPUT_PIN(rin),
    .REMOTE_OUTPUT_PIN(rout), .TAP_GROUP0(tap[0]), .TAP_GROUP1(tap[1]),
    .TAP_GROUP2(tap[2]), .TAP_GROUP3(tap[3]),
    .TAP_PIXEL_CLOCK_OUT(tap[4]), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata));

  sclf_far_end #(.GAP_CYC(8)) far (
    .clk(clk), .rst_n(rst_n), .want_level(want), .neg_code(neg_code),
    .pos_code(pos_code), .remote_pin(rin), .neg_wire(neg_w),
    .pos_wire(pos_w));

  always #2 clk = ~clk;

  // Host filter: a fault counts only once the pin stays low 3 cycles
  always @(posedge clk)
    lf_low <= lf_n ? 0 : lf_low + 1;

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Cut a hang short well past the expected few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      close_out;
    end
  end

  task automatic check_bit(input logic g, input logic e, input string m);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %0t %s got %b", $time, m, g);
    end
  endtask

  task automatic check_byte(input logic [7:0] g, input logic [7:0] e,
                            input string m);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h want %h", $time, m, g, e);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // Read data lands one cycle after the read is taken
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check_byte(rdata, e, "register read");
  endtask

  // Expected taps derive from the delay table over the tap unit
  task automatic check_taps(input logic dis);
    int d [5];
    d = '{DLY_GRP0_PS, DLY_GRP1_PS, DLY_GRP2_PS, DLY_GRP3_PS, DLY_PCLK_PS};
    for (int i = 0; i < 5; i++)
      check_byte({5'h00, tap[i]}, dis ? 8'h00 : 8'(d[i] / TAP_UNIT_PS),
                 "tap");
  endtask

  task automatic wait_valid;
    int n;
    n = 0;
    while (valid !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    #1;
    check_bit(valid, 1'b1, "strap valid");
  endtask

  initial begin
    clk = 0; rst_n = 0; local_ctrl_channel_enable = 0; g0_drv = 1; g1_drv = 0; ms_pin = 1;
    sda_drv = 0; scl_drv = 1; sda_pull = 1; scl_pull = 1; want = 0;
    neg_code = WIRE_NORMAL; pos_code = WIRE_NORMAL;
    addr = 0; wdata = 0; wr = 0; rd = 0;
    errors = 0; cmp_count = 0; cycles = 0;
    repeat (3) @(posedge clk);
    #1;
    check_taps(1'b0);
    @(posedge clk);
    rst_n <= 1'b1;
    wait_valid;
    check_bit(cc_on, 1'b0, "channel off");
    check_bit(sda_oe_n, 1'b1, "sda idle");
    check_bit(double_input_strap, 1'b1, "double");
    check_bit(w32, 1'b0, "width");
    check_bit(senc, 1'b1, "sync enc");
    check_bit(ecc, 1'b0, "correction");
    check_bit(fall, 1'b1, "edge");
    // Flip every strap pin; captured values must not follow
    @(posedge clk);
    {g0_drv, g1_drv, ms_pin, sda_drv, scl_drv} <= 5'h0A;
    repeat (6) @(posedge clk);
    #1;
    check_byte({3'h0, double_input_strap, w32, senc, ecc, fall}, 8'h15, "held");
    check_taps(1'b0);
    reg_wr(ADDR_OUT_CTRL, 8'h08);
    check_taps(1'b1);
    rd_chk(ADDR_OUT_CTRL, 8'h08);
    reg_wr(ADDR_OUT_CTRL, 8'h00);
    check_taps(1'b0);
    // Every negative and positive wire code, both fields at once
    for (int n = 0; n < 4; n++)
      for (int p = 0; p < 4; p++) begin
        @(posedge clk);
        neg_code <= 2'(n);
        pos_code <= 2'(p);
        repeat (6) @(posedge clk);
        #1;
        check_bit(lf_n, n == 2 && p == 2, "fault pin");
        check_bit(lf_low > 2, n != 2 || p != 2, "host filter");
        rd_chk(ADDR_FAULT_STAT, {4'h0, 2'(n), 2'(p)});
      end
    // Status is read-only: the write is dropped, open wires still show
    reg_wr(ADDR_FAULT_STAT, 8'h0A);
    rd_chk(ADDR_FAULT_STAT, 8'h0F);
    rd_chk(8'h15, 8'h00);
    // Remote input edges must reach the output within the limit
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      want <= ~want;
      repeat (12) @(posedge clk);
      #1;
      check_bit(rout, want, "remote out");
    end
    // Second power-up with the local channel on
    @(posedge clk);
    sda_pull <= 1'b0;
    scl_pull <= 1'b0;
    {g0_drv, g1_drv, ms_pin, sda_drv, scl_drv} <= 5'h1B;
    rst_n <= 1'b0;
    local_ctrl_channel_enable <= 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wait_valid;
    check_bit(cc_on, 1'b1, "channel on");
    check_byte({3'h0, double_input_strap, w32, senc, ecc, fall}, 8'h00, "no straps");
    check_bit(bypass, 1'b0, "base mode");
    @(posedge clk);
    ms_pin <= 1'b1;
    sda_pull <= 1'b1;
    scl_pull <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check_bit(bypass, 1'b1, "bypass mode");
    check_byte({4'h0, sda_oe_n, scl_oe_n, sda_in, scl_in}, 8'h00, "cc");
    rd_chk(ADDR_GPIO, 8'h0F);
    reg_wr(ADDR_GPIO, 8'h08);
    check_bit(g0_oe_n, 1'b0, "gpio0 low");
    repeat (3) @(posedge clk);
    rd_chk(ADDR_GPIO, 8'h0C);
    reg_wr(ADDR_GPIO, 8'h02);
    check_byte({6'h00, g1_oe_n, g0_oe_n}, 8'h01, "gpio pulls");
    close_out;
  end
endmodule
